// file: core/elic_core.sv
`timescale 1ns/10ps
// elic_core: identification, command register, logical destination and self-interrupt path
module elic_core #(
	parameter int          LOG_ID_BITS  = 16,           // implemented logical id bits
	parameter int          CLUSTER_BITS = 16,           // implemented cluster bits
	parameter logic [31:0] MAX_LEAF     = 32'h0000_000b, // highest basic leaf
	parameter logic [31:0] TOPO_EBX     = 32'h0000_0001  // topology leaf sub-leaf 0 ebx
) (
	// clock and reset
	input  wire logic          clock,
	input  wire logic          reset,
	// identity and mode
	input  wire logic [31:0]   unit_id,        // hardware unit id, held stable
	input  wire logic          ext_mode,       // extended mode enabled level
	// identification query
	input  wire logic          id_valid,
	input  wire logic [31:0]   id_leaf,
	input  wire logic [31:0]   id_subleaf,
	output logic               id_done,
	output logic [31:0]        id_eax,
	output logic [31:0]        id_ebx,
	output logic [31:0]        id_ecx,
	output logic [31:0]        id_edx,
	// register access from the core
	input  wire logic          reg_valid,
	input  wire logic          reg_write,
	input  wire logic [31:0]   reg_addr,
	input  wire logic [63:0]   reg_wdata,
	output logic               reg_done,
	output logic               reg_fault,
	output logic [63:0]        reg_rdata,
	// delivery fabric: outgoing interrupt
	output logic               ipi_valid,
	output logic [7:0]         ipi_vector,
	output logic [2:0]         ipi_dmode,
	output logic               ipi_logical,
	output logic               ipi_level,
	output logic               ipi_trigger,
	output logic [1:0]         ipi_shorthand,
	output logic [31:0]        ipi_dest,
	output logic               ipi_broadcast,
	// core acceptance of local requests
	input  wire logic          accept_valid,
	input  wire logic [7:0]    accept_vector,
	input  wire logic          eoi_valid,
	input  wire logic [7:0]    eoi_vector
);
	import elic_pkg::*;

	typedef enum logic [1:0] {
		ELIC_IDLE  = 2'b00,  // waiting for access
		ELIC_BANK  = 2'b01,  // waiting one cycle for bit-store read word
		ELIC_REPLY = 2'b10   // answer on the bus
	} elic_state_e;

	elic_state_e   st_q, st_d;           // access sequencer
	logic [63:0]   cmd_q, cmd_d;         // command register
	logic [31:0]   ldv_q, ldv_d;         // logical destination value
	logic [7:0]    self_q, self_d;       // last self vector written
	logic          ext_q, ext_d;         // previous mode, for rising-edge detect
	logic [63:0]   rdat_q, rdat_d;       // read answer
	logic          flt_q, flt_d;         // fault answer
	logic [31:0]   id_a_q, id_a_d;       // identification answers
	logic [31:0]   id_b_q, id_b_d;
	logic [31:0]   id_c_q, id_c_d;
	logic [31:0]   id_x_q, id_x_d;
	logic          idd_q, idd_d;
	logic          ipv_q, ipv_d;         // outgoing interrupt strobe
	logic [63:0]   ipc_q, ipc_d;         // outgoing command image
	logic          set_v;                // local request set
	logic [7:0]    set_vec;
	logic          set_lvl;
	logic [1:0]    bank_sel;
	logic [2:0]    bank_word;
	logic [31:0]   bank_rd;
	logic [31:0]   ld_derived;
	logic [63:0]   wcmd;
	logic [1:0]    wsh;
	logic          hit_cmd, hit_self, hit_id, hit_ld, hit_bank;

	// derive logical value; unimplemented bits forced low
	always_comb begin
		ld_derived = 32'h0;
		ld_derived[ELIC_CLUSTER_LSB +: 16] = unit_id[19:4] & 16'((17'h1 << CLUSTER_BITS) - 17'h1);
		ld_derived[15:0] = (16'h1 << unit_id[3:0]) & 16'((17'h1 << LOG_ID_BITS) - 17'h1);
	end

	// address decode; no format register exists in extended mode, so it falls to fault
	always_comb begin
		hit_cmd  = reg_addr == ELIC_ADDR_CMD;
		hit_self = reg_addr == ELIC_ADDR_SELF;
		hit_id   = reg_addr == ELIC_ADDR_UNIT_ID;
		hit_ld   = reg_addr == ELIC_ADDR_LOGICAL;
		hit_bank = (reg_addr[31:3] == ELIC_ADDR_REQ_BASE[31:3]) || (reg_addr[31:3] == ELIC_ADDR_SRV_BASE[31:3])
			|| (reg_addr[31:3] == ELIC_ADDR_TRG_BASE[31:3]);
		bank_word = reg_addr[2:0];
		if (reg_addr[31:3] == ELIC_ADDR_REQ_BASE[31:3])
			bank_sel = 2'h0;
		else if (reg_addr[31:3] == ELIC_ADDR_SRV_BASE[31:3])
			bank_sel = 2'h1;
		else
			bank_sel = 2'h2;
	end

	// command write image: reserved low bits and the removed status bit dropped
	always_comb begin
		wcmd = {reg_wdata[63:32], reg_wdata[31:0] & ELIC_CMD_LO_MASK};
		wsh  = wcmd[ELIC_CMD_SH_LSB +: 2];
	end

	// access sequencer and register updates
	always_comb begin
		st_d    = st_q;
		cmd_d   = cmd_q;
		ldv_d   = ldv_q;
		self_d  = self_q;
		ext_d   = ext_mode;
		rdat_d  = rdat_q;
		flt_d   = 1'b0;
		ipv_d   = 1'b0;
		ipc_d   = ipc_q;
		set_v   = 1'b0;
		set_vec = 8'h0;
		set_lvl = 1'b0;
		// reload the logical value on every entry to extended mode
		if (ext_mode && !ext_q)
			ldv_d = ld_derived;
		unique case (st_q)
			ELIC_IDLE: begin
				if (reg_valid) begin
					st_d   = ELIC_REPLY;
					rdat_d = 64'h0;
					if (!ext_mode) begin
						flt_d = 1'b1;  // registers only reachable in extended mode
					end else if (reg_write) begin
						if (hit_cmd) begin
							// one write dispatches
							cmd_d = wcmd;
							ipv_d = 1'b1;
							ipc_d = wcmd;
							// self shorthand lands locally
							if (wsh == ELIC_SH_SELF || wsh == ELIC_SH_ALL_INCL) begin
								set_v   = 1'b1;
								set_vec = wcmd[ELIC_CMD_VEC_LSB +: 8];
								set_lvl = wcmd[ELIC_CMD_TRIG_BIT];
							end
						end else if (hit_self) begin
							// only the vector is used
							self_d  = reg_wdata[7:0] & ELIC_SELF_VEC_MASK[7:0];
							// fixed edge self interrupt, set on the same edge that completes the write
							set_v   = 1'b1;
							set_vec = reg_wdata[7:0];
							set_lvl = 1'b0;
						end else begin
							flt_d = 1'b1;  // read-only or unmapped
						end
					end else begin
						if (hit_self)
							flt_d = 1'b1;  // write-only register
						else if (hit_id)
							rdat_d = {32'h0, unit_id};
						else if (hit_ld)
							rdat_d = {32'h0, ldv_q};
						else if (hit_cmd)
							rdat_d = cmd_q;  // debug view only, may differ from last write
						else if (hit_bank)
							st_d = ELIC_BANK;
						else
							flt_d = 1'b1;
					end
				end
			end
			ELIC_BANK: begin
				rdat_d = {32'h0, bank_rd};
				st_d   = ELIC_REPLY;
			end
			ELIC_REPLY: begin
				st_d = ELIC_IDLE;
			end
			default: st_d = ELIC_IDLE;
		endcase
	end

	// identification answers
	always_comb begin
		idd_d  = id_valid;
		id_a_d = 32'h0;
		id_b_d = 32'h0;
		id_c_d = 32'h0;
		id_x_d = 32'h0;
		if (id_leaf == ELIC_LEAF_BASIC)
			id_a_d = MAX_LEAF;
		else if (id_leaf == ELIC_LEAF_FEATURE) begin
			id_c_d[ELIC_EXT_FEAT_BIT] = 1'b1;
			id_b_d[ELIC_INIT_ID_LSB +: 8] = unit_id[7:0];
		end else if (id_leaf == ELIC_LEAF_TOPO) begin
			// non-zero ebx on sub-leaf 0; zero would mean unsupported
			id_b_d = (id_subleaf == 32'h0) ? TOPO_EBX : 32'h0;
			id_x_d = unit_id; // full id in either mode
		end
	end

	// register all state
	always_ff @(posedge clock) begin
		if (reset) begin
			st_q   <= ELIC_IDLE;
			cmd_q  <= ELIC_CMD_RESET;
			ldv_q  <= 32'h0;
			self_q <= ELIC_SELF_RESET;
			ext_q  <= 1'b0;
			rdat_q <= 64'h0;
			flt_q  <= 1'b0;
			ipv_q  <= 1'b0;
			ipc_q  <= 64'h0;
			idd_q  <= 1'b0;
			id_a_q <= 32'h0;
			id_b_q <= 32'h0;
			id_c_q <= 32'h0;
			id_x_q <= 32'h0;
		end else begin
			st_q   <= st_d;
			cmd_q  <= cmd_d;
			ldv_q  <= ldv_d;
			self_q <= self_d;
			ext_q  <= ext_d;
			rdat_q <= rdat_d;
			flt_q  <= flt_d;
			ipv_q  <= ipv_d;
			ipc_q  <= ipc_d;
			idd_q  <= idd_d;
			id_a_q <= id_a_d;
			id_b_q <= id_b_d;
			id_c_q <= id_c_d;
			id_x_q <= id_x_d;
		end
	end

	// local request bit store
	elic_vec_bits #(
		.NVEC(256)
	) u_bits (
		.clock         (clock),
		.reset         (reset),
		.set_valid     (set_v),
		.set_vector    (set_vec),
		.set_level     (set_lvl),
		.accept_valid  (accept_valid),
		.accept_vector (accept_vector),
		.eoi_valid     (eoi_valid),
		.eoi_vector    (eoi_vector),
		.rd_sel        (bank_sel),
		.rd_word       (bank_word),
		.rd_data       (bank_rd)
	);

	// outputs
	assign reg_done      = (st_q == ELIC_REPLY);
	assign reg_fault     = flt_q;
	assign reg_rdata     = rdat_q;
	assign id_done       = idd_q;
	assign id_eax        = id_a_q;
	assign id_ebx        = id_b_q;
	assign id_ecx        = id_c_q;
	assign id_edx        = id_x_q;
	assign ipi_valid     = ipv_q;
	assign ipi_vector    = ipc_q[ELIC_CMD_VEC_LSB +: 8];
	assign ipi_dmode     = ipc_q[ELIC_CMD_DMODE_LSB +: 3];
	assign ipi_logical   = ipc_q[ELIC_CMD_DEST_MODE];
	assign ipi_level     = ipc_q[ELIC_CMD_LEVEL_BIT];
	assign ipi_trigger   = ipc_q[ELIC_CMD_TRIG_BIT];
	assign ipi_shorthand = ipc_q[ELIC_CMD_SH_LSB +: 2];
	assign ipi_dest      = ipc_q[ELIC_CMD_DEST_LSB +: 32];
	assign ipi_broadcast = (ipc_q[ELIC_CMD_DEST_LSB +: 32] == ELIC_DEST_BCAST);
endmodule

// file: core/elic_pkg.sv
// elic_pkg: constants, register map and field layout for the extended local interrupt unit
// Behaviour
// - leaf 01H ecx bit 21 reads one
// - leaf 0BH sub-leaf 0 ebx non-zero
// - leaf 0BH edx gives full unit id
// - leaf 01H ebx[31:24] equals unit id[7:0]
// - register 802H equals leaf 0BH edx
// - command low word legacy, no status bit
// - one command write dispatches the interrupt
// - command readable, readback not guaranteed
// - all-ones destination means broadcast
// - logical destination 32-bit, read-only, 80DH
// - only clustered mode, no format register
// - cluster in 31:16, logical id 15:0
// - unimplemented logical bits read zero
// - derive cluster and one-hot from unit id
// - reload logical value on extended enable
// - self register 083FH write-only, vector 7:0
// - reading self register raises protection fault
// - self write equals fixed edge self command
// - vector set in request register on completion
// - same-vector edge self requests may merge
// - zero ebx above 0BH means unsupported
// - self register cleared by reset
package elic_pkg;
	// register addresses
	localparam logic [31:0] ELIC_ADDR_UNIT_ID  = 32'h0000_0802;
	localparam logic [31:0] ELIC_ADDR_LOGICAL  = 32'h0000_080d;
	localparam logic [31:0] ELIC_ADDR_CMD      = 32'h0000_0830;
	localparam logic [31:0] ELIC_ADDR_SELF     = 32'h0000_083f;
	localparam logic [31:0] ELIC_ADDR_REQ_BASE = 32'h0000_0820;
	localparam logic [31:0] ELIC_ADDR_SRV_BASE = 32'h0000_0810;
	localparam logic [31:0] ELIC_ADDR_TRG_BASE = 32'h0000_0818;
	// identification leaves
	localparam logic [31:0] ELIC_LEAF_BASIC    = 32'h0000_0000;
	localparam logic [31:0] ELIC_LEAF_FEATURE  = 32'h0000_0001;
	localparam logic [31:0] ELIC_LEAF_TOPO     = 32'h0000_000b;
	localparam int          ELIC_EXT_FEAT_BIT  = 21;
	localparam int          ELIC_INIT_ID_LSB   = 24;
	// command field positions
	localparam int          ELIC_CMD_VEC_LSB   = 0;
	localparam int          ELIC_CMD_DMODE_LSB = 8;
	localparam int          ELIC_CMD_DEST_MODE = 11;
	localparam int          ELIC_CMD_LEVEL_BIT = 14;
	localparam int          ELIC_CMD_TRIG_BIT  = 15;
	localparam int          ELIC_CMD_SH_LSB    = 18;
	localparam int          ELIC_CMD_DEST_LSB  = 32;
	localparam logic [1:0]  ELIC_SH_NONE       = 2'h0;
	localparam logic [1:0]  ELIC_SH_SELF       = 2'h1;
	localparam logic [1:0]  ELIC_SH_ALL_INCL   = 2'h2;
	localparam logic [1:0]  ELIC_SH_ALL_EXCL   = 2'h3;
	localparam logic [2:0]  ELIC_DM_FIXED      = 3'h0;
	localparam logic [31:0] ELIC_DEST_BCAST    = 32'hffff_ffff;
	// writable command bits of the low word: vector, delivery, dest mode, level, trigger, shorthand
	localparam logic [31:0] ELIC_CMD_LO_MASK   = 32'h000c_cfff;
	localparam logic [31:0] ELIC_SELF_VEC_MASK = 32'h0000_00ff;
	// logical destination split
	localparam int          ELIC_CLUSTER_LSB   = 16;
	localparam logic [63:0] ELIC_CMD_RESET     = 64'h0;
	localparam logic [7:0]  ELIC_SELF_RESET    = 8'h0;
endpackage

// file: core/elic_vec_bits.sv
`timescale 1ns/10ps
// elic_vec_bits: 256-entry request / in-service / trigger bit store with registered read word
module elic_vec_bits #(
	parameter int NVEC = 256
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             reset,
	// set request from self path
	input  wire logic             set_valid,
	input  wire logic [7:0]       set_vector,
	input  wire logic             set_level,
	// core acceptance
	input  wire logic             accept_valid,
	input  wire logic [7:0]       accept_vector,
	input  wire logic             eoi_valid,
	input  wire logic [7:0]       eoi_vector,
	// word read: sel 0 request, 1 service, 2 trigger; word index 0..7
	input  wire logic [1:0]       rd_sel,
	input  wire logic [2:0]       rd_word,
	output logic      [31:0]      rd_data
);
	logic [NVEC-1:0] req_q, req_d;   // pending requests
	logic [NVEC-1:0] srv_q, srv_d;   // in service
	logic [NVEC-1:0] trg_q, trg_d;   // level-trigger marks
	logic [31:0]     rd_q, rd_d;     // registered read word

	// per-vector next state; a set in the same cycle as acceptance wins so nothing is lost
	genvar v;
	generate
		for (v = 0; v < NVEC; v++) begin : g_vec
			always_comb begin
				req_d[v] = req_q[v];
				srv_d[v] = srv_q[v];
				trg_d[v] = trg_q[v];
				// end of service first, so a same-cycle acceptance of that vector keeps it in service
				if (eoi_valid && eoi_vector == 8'(v))
					srv_d[v] = 1'b0;
				if (accept_valid && accept_vector == 8'(v)) begin
					req_d[v] = 1'b0;
					srv_d[v] = 1'b1;
				end
				// an already pending edge request simply stays set: repeats merge
				if (set_valid && set_vector == 8'(v)) begin
					req_d[v] = 1'b1;
					trg_d[v] = set_level;
				end
			end
		end
	endgenerate

	// read word mux
	always_comb begin
		unique case (rd_sel)
			2'h0:    rd_d = req_q[rd_word*32 +: 32];
			2'h1:    rd_d = srv_q[rd_word*32 +: 32];
			2'h2:    rd_d = trg_q[rd_word*32 +: 32];
			default: rd_d = 32'h0;
		endcase
	end

	// register state
	always_ff @(posedge clock) begin
		if (reset) begin
			req_q <= '0;
			srv_q <= '0;
			trg_q <= '0;
			rd_q  <= 32'h0;
		end else begin
			req_q <= req_d;
			srv_q <= srv_d;
			trg_q <= trg_d;
			rd_q  <= rd_d;
		end
	end

	assign rd_data = rd_q;
endmodule

// file: sim/elic_core_checker.sv
// elic_core_checker: concurrent checks on the extended interrupt unit ports
`timescale 1ns/10ps
module elic_core_checker
	import elic_pkg::*;
#(
	parameter int LOG_ID_BITS  = 16,
	parameter int CLUSTER_BITS = 16
) (
	input wire logic        clock,
	input wire logic        reset,
	input wire logic [31:0] unit_id,
	input wire logic        ext_mode,
	input wire logic        id_valid,
	input wire logic [31:0] id_leaf,
	input wire logic [31:0] id_subleaf,
	input wire logic        id_done,
	input wire logic [31:0] id_eax,
	input wire logic [31:0] id_ebx,
	input wire logic [31:0] id_ecx,
	input wire logic [31:0] id_edx,
	input wire logic        reg_valid,
	input wire logic        reg_write,
	input wire logic [31:0] reg_addr,
	input wire logic [63:0] reg_wdata,
	input wire logic        reg_done,
	input wire logic        reg_fault,
	input wire logic [63:0] reg_rdata,
	input wire logic        ipi_valid,
	input wire logic [7:0]  ipi_vector,
	input wire logic [31:0] ipi_dest,
	input wire logic        ipi_broadcast
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// expected logical value, narrowed so unimplemented bits read zero
	logic [31:0] ldr_exp;
	assign ldr_exp = {unit_id[19:4] & 16'((1 << CLUSTER_BITS) - 1), 16'((1 << unit_id[3:0]) & ((1 << LOG_ID_BITS) - 1))};
	// an access is in flight, so a request still held over its answer is not a new one
	logic busy_q;
	always_ff @(posedge clock) begin
		if (reset)
			busy_q <= 1'b0;
		else if (reg_done)
			busy_q <= 1'b0;
		else if (reg_valid)
			busy_q <= 1'b1;
	end
	// one register request in extended mode
	sequence rd_s(a);
		reg_valid && !busy_q && !reg_write && ext_mode && reg_addr == a;
	endsequence
	sequence wr_s(a);
		reg_valid && !busy_q && reg_write && ext_mode && reg_addr == a;
	endsequence
	feat_bit_a: assert property (id_valid && id_leaf == ELIC_LEAF_FEATURE |=>
		id_done && id_ecx[21] && id_ebx[31:24] == unit_id[7:0]) else $error("feature leaf answer wrong");
	topo_leaf_a: assert property (id_valid && id_leaf == ELIC_LEAF_TOPO && id_subleaf == 0 |=>
		id_ebx != 0 && id_edx == unit_id) else $error("topology leaf answer wrong");
	max_leaf_a: assert property (id_valid && id_leaf == ELIC_LEAF_BASIC |=>
		id_eax >= 32'h0000_000b) else $error("basic leaf too low");
	unit_read_a: assert property (rd_s(ELIC_ADDR_UNIT_ID) |=>
		reg_done && !reg_fault && reg_rdata[31:0] == unit_id) else $error("unit id read wrong");
	ldr_read_a: assert property (rd_s(ELIC_ADDR_LOGICAL) |=>
		reg_done && !reg_fault && reg_rdata[31:0] == ldr_exp) else $error("logical value wrong");
	ldr_ro_a: assert property (wr_s(ELIC_ADDR_LOGICAL) or rd_s(32'h0000_080e) |=>
		reg_done && reg_fault) else $error("logical write or format read not refused");
	self_rd_a: assert property (rd_s(ELIC_ADDR_SELF) |=> reg_done && reg_fault)
		else $error("self register read not refused");
	self_wr_a: assert property (wr_s(ELIC_ADDR_SELF) |=> reg_done && !reg_fault && !ipi_valid)
		else $error("self write misbehaved");
	cmd_send_a: assert property (wr_s(ELIC_ADDR_CMD) |=> ipi_valid &&
		ipi_vector == $past(reg_wdata[7:0]) && ipi_dest == $past(reg_wdata[63:32])) else $error("command not sent");
	bcast_a: assert property (wr_s(ELIC_ADDR_CMD) |=>
		ipi_broadcast == ($past(reg_wdata[63:32]) == ELIC_DEST_BCAST)) else $error("broadcast flag wrong");
endmodule
bind elic_core elic_core_checker #(.LOG_ID_BITS(LOG_ID_BITS), .CLUSTER_BITS(CLUSTER_BITS)) u_elic_core_checker (
	.clock, .reset, .unit_id, .ext_mode, .id_valid, .id_leaf, .id_subleaf, .id_done, .id_eax, .id_ebx,
	.id_ecx, .id_edx, .reg_valid, .reg_write, .reg_addr, .reg_wdata, .reg_done, .reg_fault, .reg_rdata,
	.ipi_valid, .ipi_vector, .ipi_dest, .ipi_broadcast);

// file: sim/elic_host_model.sv
// elic_host_model: processor core side issuing register reads and writes
`timescale 1ns/10ps
module elic_host_model (
	// clock
	input  wire logic        clock,
	// request
	output logic             reg_valid,
	output logic             reg_write,
	output logic [31:0]      reg_addr,
	output logic [63:0]      reg_wdata,
	// answer
	input  wire logic        reg_done,
	input  wire logic        reg_fault,
	input  wire logic [63:0] reg_rdata
);
	initial begin
		reg_valid = 1'b0;
		reg_write = 1'b0;
		reg_addr  = 32'h0;
		reg_wdata = 64'h0;
	end
	// one access; request held until the edge that samples done, which the design ignores while busy
	task automatic access(input logic wr, input logic [31:0] a, input logic [63:0] d, input int gap,
		output logic f, output logic [63:0] q);
		int n;
		repeat (gap) @(negedge clock);
		@(negedge clock);
		reg_valid = 1'b1;
		reg_write = wr;
		reg_addr  = a;
		reg_wdata = d;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (reg_done !== 1'b1 && n < 8);
		// answer taken while it stands; a lost answer returns unknowns so the caller's compare fails
		f = (reg_done === 1'b1) ? reg_fault : 1'bx;
		q = (reg_done === 1'b1) ? reg_rdata : 64'hx;
		// let the edge that samples done pass before releasing
		@(negedge clock);
		reg_valid = 1'b0;
		// released lines show the inverse so stale values cannot pass
		reg_addr  = ~a;
		reg_wdata = ~d;
	endtask
endmodule

// file: sim/ext_ipi_and_logical_id_test.sv
// ext_ipi_and_logical_id_test: directed identification, register and self interrupt tests
`timescale 1ns/10ps
module ext_ipi_and_logical_id_test;
	import elic_pkg::*;
	logic        clock, reset, ext_mode, id_valid, id_done;
	logic [31:0] unit_id, id_leaf, id_subleaf, id_eax, id_ebx, id_ecx, id_edx, reg_addr, ipi_dest;
	logic        reg_valid, reg_write, reg_done, reg_fault;
	logic [63:0] reg_wdata, reg_rdata;
	logic        ipi_valid, ipi_logical, ipi_level, ipi_trigger, ipi_broadcast;
	logic [7:0]  ipi_vector, accept_vector, eoi_vector;
	logic [2:0]  ipi_dmode;
	logic [1:0]  ipi_shorthand;
	logic        accept_valid, eoi_valid;
	int          err_total;
	int          total_checks;
	int          ipi_seen = 0;   // fabric pulses seen
	elic_core u_elic_core (.clock(clock), .reset(reset), .unit_id(unit_id), .ext_mode(ext_mode),
		.id_valid(id_valid), .id_leaf(id_leaf), .id_subleaf(id_subleaf), .id_done(id_done), .id_eax(id_eax),
		.id_ebx(id_ebx), .id_ecx(id_ecx), .id_edx(id_edx), .reg_valid(reg_valid), .reg_write(reg_write),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_done(reg_done), .reg_fault(reg_fault),
		.reg_rdata(reg_rdata), .ipi_valid(ipi_valid), .ipi_vector(ipi_vector), .ipi_dmode(ipi_dmode),
		.ipi_logical(ipi_logical), .ipi_level(ipi_level), .ipi_trigger(ipi_trigger),
		.ipi_shorthand(ipi_shorthand), .ipi_dest(ipi_dest), .ipi_broadcast(ipi_broadcast),
		.accept_valid(accept_valid), .accept_vector(accept_vector), .eoi_valid(eoi_valid), .eoi_vector(eoi_vector));
	elic_host_model u_elic_host_model (.clock(clock), .reg_valid(reg_valid), .reg_write(reg_write),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_done(reg_done), .reg_fault(reg_fault), .reg_rdata(reg_rdata));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// count one-cycle fabric pulses where they are settled
	always @(negedge clock) begin
		if (ipi_valid === 1'b1)
			ipi_seen++;
	end
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask
	// register access; data compared only for a clean read with a known expectation
	task automatic rchk(input logic w, input logic [31:0] a, input logic [63:0] d, input logic ef, input logic [63:0] eq);
		logic f;
		logic [63:0] q;
		u_elic_host_model.access(w, a, d, a[0], f, q);
		chk($sformatf("fault at %h", a), {63'h0, ef}, {63'h0, f});
		if (!w && !ef && eq !== 64'hx)
			chk($sformatf("data at %h", a), eq, q);
	endtask
	task automatic idq(input logic [31:0] leaf);
		@(negedge clock);
		id_valid   = 1'b1;
		id_leaf    = leaf;
		id_subleaf = 32'h0;
		@(negedge clock);
		chk("id done", 64'h1, {63'h0, id_done});
		@(negedge clock);
		id_valid = 1'b0;
	endtask
	// core takes (acc=1) or finishes (acc=0) one vector
	task automatic take(input logic acc, input logic [7:0] v);
		@(negedge clock);
		accept_valid  = acc;
		eoi_valid     = !acc;
		accept_vector = v;
		eoi_vector    = v;
		@(negedge clock);
		accept_valid = 1'b0;
		eoi_valid    = 1'b0;
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		$display("ERROR watchdog expected finish seen hang");
		err_total++;
		give_verdict();
	end
	initial begin
		// wide id, so extended mode stays on from reset
		reset = 1'b1;
		unit_id = 32'h0012_345b;
		ext_mode = 1'b1;
		{id_valid, id_leaf, id_subleaf, accept_valid, accept_vector, eoi_valid, eoi_vector} = '0;
		err_total = 0;
		total_checks = 0;
		repeat (20) @(negedge clock);
		reset = 1'b0;
		idq(ELIC_LEAF_BASIC);
		chk("max leaf", 64'hb, {32'h0, id_eax});
		idq(ELIC_LEAF_FEATURE);
		chk("feature bit", 64'h1, {63'h0, id_ecx[21]});
		chk("initial id", 64'h5b, {56'h0, id_ebx[31:24]});
		idq(ELIC_LEAF_TOPO);
		chk("topo ebx", 64'h1, {32'h0, id_ebx});
		chk("topo edx", 64'h0012_345b, {32'h0, id_edx});
		$display("test identification done");
		rchk(0, ELIC_ADDR_UNIT_ID, 0, 0, 64'h0012_345b);
		rchk(0, ELIC_ADDR_LOGICAL, 0, 0, 64'h2345_0800);
		rchk(1, ELIC_ADDR_LOGICAL, 64'h1, 1, 'x);
		rchk(0, 32'h0000_080e, 0, 1, 'x);
		rchk(0, ELIC_ADDR_SELF, 0, 1, 'x);
		rchk(0, 32'h0000_0900, 0, 1, 'x);
		$display("test registers done");
		rchk(1, ELIC_ADDR_CMD, {32'hffff_ffff, 32'h0000_fc30}, 0, 'x);
		chk("logical bcast", 64'h4f, {57'h0, ipi_dmode, ipi_level, ipi_trigger, ipi_logical, ipi_broadcast});
		rchk(0, ELIC_ADDR_CMD, 0, 0, {32'hffff_ffff, 32'h0000_cc30});
		rchk(1, ELIC_ADDR_CMD, {32'h5, 32'h0004_0030}, 0, 'x);
		chk("shorthand", {62'h0, ELIC_SH_SELF}, {62'h0, ipi_shorthand});
		chk("dest", 64'h5, {32'h0, ipi_dest});
		chk("phys no bcast", 64'h30, {55'h0, ipi_broadcast, ipi_vector});
		rchk(0, ELIC_ADDR_CMD, 0, 0, {32'h5, 32'h0004_0030});
		rchk(0, ELIC_ADDR_REQ_BASE + 32'h1, 0, 0, 64'h0001_0000);
		chk("ipi pulses", 64'h2, 64'(ipi_seen));
		$display("test command done");
		rchk(1, ELIC_ADDR_SELF, 64'hffff_ffff_ffff_ff41, 0, 'x);
		rchk(0, ELIC_ADDR_REQ_BASE + 32'h2, 0, 0, 64'h2);
		rchk(1, ELIC_ADDR_SELF, 64'h41, 0, 'x);
		rchk(0, ELIC_ADDR_TRG_BASE + 32'h2, 0, 0, 64'h0);
		take(1, 8'h41);
		rchk(0, ELIC_ADDR_REQ_BASE + 32'h2, 0, 0, 64'h0);
		rchk(0, ELIC_ADDR_SRV_BASE + 32'h2, 0, 0, 64'h2);
		take(0, 8'h41);
		rchk(0, ELIC_ADDR_SRV_BASE + 32'h2, 0, 0, 64'h0);
		chk("ipi pulses self", 64'h2, 64'(ipi_seen));
		$display("test self interrupt done");
		@(negedge clock);
		reset = 1'b1;
		unit_id = 32'h0000_00f0;
		ext_mode = 1'b0;
		repeat (20) @(negedge clock);
		reset = 1'b0;
		rchk(0, ELIC_ADDR_LOGICAL, 0, 1, 'x);
		@(negedge clock);
		ext_mode = 1'b1;
		rchk(0, ELIC_ADDR_REQ_BASE + 32'h1, 0, 0, 64'h0);
		rchk(0, ELIC_ADDR_LOGICAL, 0, 0, 64'h000f_0001);
		$display("test mode enable done");
		give_verdict();
	end
endmodule
